//--- burst4_pkg.sv
/*
 * Shared constants, types and lane-mask helpers for the four-word burst
 * write-mask and burst-order block.
 * Assumes a single system clock that is much faster than the controller's
 * input clock pair, so that every input clock edge is seen as a level change.
 */
package burst4_pkg;

    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int NIB_W = 4;
    localparam int BYTE_LANES = 4;
    localparam int NIB_LANES = 2;
    localparam int ADDR_HI_W = 3;
    localparam int WORDS = 1 << (ADDR_HI_W + 2);
    localparam logic [1:0] LAST_BEAT = 2'h3;
    localparam logic [1:0] MID_BEAT = 2'h2;
    localparam logic [1:0] FIRST_BEAT = 2'h0;

    typedef enum logic [1:0]
    {
        VAR_X8 = 2'h0,
        VAR_X9 = 2'h1,
        VAR_X18 = 2'h2,
        VAR_X36 = 2'h3
    } variant_t;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h1,
        ST_WRITE = 3'h2,
        ST_READ = 3'h4
    } job_state_t;

    typedef struct packed
    {
        logic k;
        logic kn;
        logic load_n;
        logic rw;
        logic [ADDR_HI_W-1:0] addr;
        logic start_lo;
        logic start_hi;
        logic [DATA_W-1:0] d;
        logic [BYTE_LANES-1:0] bw_n;
        logic [NIB_LANES-1:0] nw_n;
    } pins_t;

    // Idle pin levels: no request, read select high, all lanes disabled
    localparam pins_t PINS_RESET = '{
        k: 1'h0, kn: 1'h0, load_n: 1'h1, rw: 1'h1, addr: 3'h0,
        start_lo: 1'h0, start_hi: 1'h0, d: 36'h0, bw_n: 4'hF, nw_n: 2'h3};

    // Burst start pins exist only on the wide variants
    function automatic logic has_start(input variant_t v);
        return (v == VAR_X18) || (v == VAR_X36);
    endfunction

    // Bit mask of the lanes whose active-low enable is low
    function automatic logic [DATA_W-1:0] lane_mask(
        input variant_t v,
        input logic [BYTE_LANES-1:0] bw_n,
        input logic [NIB_LANES-1:0] nw_n);
        logic [DATA_W-1:0] m;
        m = '0;
        case (v)
            VAR_X8:
            begin
                for (int i = 0; i < NIB_LANES; i++)
                    m[i*NIB_W +: NIB_W] = {NIB_W{~nw_n[i]}};
            end
            VAR_X9:
            begin
                m[LANE_W-1:0] = {LANE_W{~bw_n[0]}};
            end
            VAR_X18:
            begin
                for (int i = 0; i < 2; i++)
                    m[i*LANE_W +: LANE_W] = {LANE_W{~bw_n[i]}};
            end
            default:
            begin
                for (int i = 0; i < BYTE_LANES; i++)
                    m[i*LANE_W +: LANE_W] = {LANE_W{~bw_n[i]}};
            end
        endcase
        return m;
    endfunction

endpackage

//--- pin_sync.sv
/*
 * Two-flip-flop synchroniser for a bundle of pin inputs.
 * Assumes each bit is a slow level relative to the clock; the bundle is not
 * guaranteed coherent within a cycle of a change.
 */
module pin_sync
    import burst4_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Bundle
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end

endmodule

//--- burst4_write_mask_and_order.sv
/*
 * Device-side logic of a four-word burst synchronous memory: request
 * decode on the primary input clock, lane-masked write capture on both input
 * clock rising edges, wrapping linear burst order, and read-back.
 * Assumes the controller's clock pair and signals are far slower than CLK_I
 * and hold each level for at least three CLK_I cycles around every edge.
 */
//
// Behaviour
// - Lane write controls are sampled on primary and complementary clock rising edges.
// - A lane is stored only when its active-low write control is low.
// - Primary edges capture words one and three, complementary edges two and four.
// - A read right after a write to that address returns new data.
// - Burst words run linearly from the two low address bits, wrapping modulo four.
// - Burst start pins are honoured only on the 18- and 36-bit variants.
// - Only the lane controls matching the variant's data organisation are used.
// - Write select on the second primary edge after a read gives a no-op.
module burst4_write_mask_and_order
    import burst4_pkg::*;
#(
    parameter variant_t VARIANT = VAR_X36
)
(
    // System
    input wire logic CLK_I,
    input wire logic NRST_I,
    // Controller clocks and requests
    input wire logic K_I,
    input wire logic KN_I,
    input wire logic LOAD_REQUEST_N_I,
    input wire logic READ_NOT_WRITE_I,
    input wire logic [ADDR_HI_W-1:0] SYNC_ADDRESS_BUS_I,
    input wire logic BURST_START_BIT_LOW_I,
    input wire logic BURST_START_BIT_HIGH_I,
    // Write data and lane controls
    input wire logic [DATA_W-1:0] D_I,
    input wire logic [BYTE_LANES-1:0] BYTE_LANE_WRITE_ENABLE_N_I,
    input wire logic [NIB_LANES-1:0] NIBBLE_LANE_WRITE_ENABLE_N_I,
    // Read data
    output logic [DATA_W-1:0] Q_O,
    output logic QVALID_O
);

    pins_t raw;
    pins_t pin;
    logic k_prev, kn_prev, k_rise, kn_rise;
    logic slot_odd, last_read, req_valid, req_write;
    logic [ADDR_HI_W-1:0] req_addr, job_addr, addr_now;
    logic [1:0] req_start, job_start, start_now, beat, beat_now, prev_lo;
    job_state_t state;
    logic use_req, do_beat, wr_now;
    logic [ADDR_HI_W+1:0] idx;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] mem [WORDS];
    logic [DATA_W-1:0] present;

    always_comb
    begin
        raw = PINS_RESET;
        raw.k = K_I;
        raw.kn = KN_I;
        raw.load_n = LOAD_REQUEST_N_I;
        raw.rw = READ_NOT_WRITE_I;
        raw.addr = SYNC_ADDRESS_BUS_I;
        raw.start_lo = BURST_START_BIT_LOW_I;
        raw.start_hi = BURST_START_BIT_HIGH_I;
        raw.d = D_I;
        raw.bw_n = BYTE_LANE_WRITE_ENABLE_N_I;
        raw.nw_n = NIBBLE_LANE_WRITE_ENABLE_N_I;
    end

    pin_sync #(
        .W($bits(pins_t)),
        .RST_VAL(PINS_RESET)
    ) u_sync (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .d_i(raw),
        .q_o(pin)
    );

    // Rising-edge detection of the input clock pair
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            k_prev <= 1'h0;
            kn_prev <= 1'h0;
        end
        else
        begin
            k_prev <= pin.k;
            kn_prev <= pin.kn;
        end
    end

    assign k_rise = pin.k & ~k_prev;
    assign kn_rise = pin.kn & ~kn_prev;

    // Request decode, one request per two primary clock cycles
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            slot_odd <= 1'h0;
            last_read <= 1'h0;
            req_valid <= 1'h0;
            req_write <= 1'h0;
            req_addr <= '0;
            req_start <= 2'h0;
        end
        else if (k_rise)
        begin
            if (slot_odd)
            begin
                slot_odd <= 1'h0;
                req_valid <= 1'h0;
            end
            else if (!pin.load_n && last_read && !pin.rw)
            begin
                req_valid <= 1'h0;
                last_read <= 1'h0;
            end
            else if (!pin.load_n)
            begin
                slot_odd <= 1'h1;
                req_valid <= 1'h1;
                req_write <= ~pin.rw;
                last_read <= pin.rw;
                req_addr <= pin.addr;
                // start pins only on wide parts
                req_start <= has_start(VARIANT) ? {pin.start_hi, pin.start_lo} : 2'h0;
            end
            else
            begin
                req_valid <= 1'h0;
                last_read <= 1'h0;
            end
        end
    end

    // even words on primary edges, odd words on complementary edges
    assign use_req = k_rise & req_valid;
    assign do_beat = use_req
                   | (k_rise & (state != ST_IDLE) & (beat == MID_BEAT))
                   | (kn_rise & (state != ST_IDLE) & beat[0]);
    assign beat_now = use_req ? FIRST_BEAT : beat;
    assign wr_now = use_req ? req_write : (state == ST_WRITE);
    assign addr_now = use_req ? req_addr : job_addr;
    assign start_now = use_req ? req_start : job_start;
    // wrapping linear order from the start word
    assign idx = {addr_now, 2'(start_now + beat_now)};
    // controls sampled at the same edge as the word
    assign mask = lane_mask(VARIANT, pin.bw_n, pin.nw_n);
    assign present = lane_mask(VARIANT, '0, '0);

    // Burst sequencing
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            state <= ST_IDLE;
            beat <= FIRST_BEAT;
            job_addr <= '0;
            job_start <= 2'h0;
            prev_lo <= 2'h0;
        end
        else
        begin
            if (do_beat)
                prev_lo <= idx[1:0];
            if (use_req)
            begin
                state <= req_write ? ST_WRITE : ST_READ;
                beat <= 2'h1;
                job_addr <= req_addr;
                job_start <= req_start;
            end
            else if (do_beat)
            begin
                case (state)
                    ST_WRITE, ST_READ:
                    begin
                        if (beat == LAST_BEAT)
                        begin
                            state <= ST_IDLE;
                            beat <= FIRST_BEAT;
                        end
                        else
                            beat <= beat + 2'h1;
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                        beat <= FIRST_BEAT;
                    end
                endcase
            end
        end
    end

    // Storage array, each word lane-masked on write
    for (genvar e = 0; e < WORDS; e++)
    begin : g_word
        always_ff @(posedge CLK_I or negedge NRST_I)
        begin
            if (!NRST_I)
                mem[e] <= '0;
            else if (do_beat && wr_now && (idx == (ADDR_HI_W+2)'(e)))
                mem[e] <= (mem[e] & ~mask) | (pin.d & mask);
        end
    end

    // words commit at capture, so a following read sees them
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            Q_O <= '0;
            QVALID_O <= 1'h0;
        end
        else
        begin
            QVALID_O <= do_beat & ~wr_now;
            if (do_beat && !wr_now)
                Q_O <= mem[idx];
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    chk_lane_store_enabled: assert property (
        (do_beat && wr_now) |=>
            (((mem[$past(idx)] ^ $past(pin.d)) & $past(mask)) == '0))
        else $error("enabled lane not stored");

    chk_lane_keep_disabled: assert property (
        (do_beat && wr_now) |=>
            (((mem[$past(idx)] ^ $past(mem[idx])) & ~$past(mask)) == '0))
        else $error("disabled lane changed");

    chk_absent_lanes_zero: assert property (
        (mem[idx] & ~present) == '0)
        else $error("lane absent on this variant was written");

    chk_beat_edge_kind: assert property (
        do_beat |-> (beat_now[0] ? (kn_rise && !k_rise) : k_rise))
        else $error("burst word taken on wrong clock edge");

    chk_burst_order_step: assert property (
        (do_beat && (beat_now != FIRST_BEAT)) |-> (idx[1:0] == 2'(prev_lo + 2'h1)))
        else $error("burst word order not linear");

    chk_start_pins_used: assert property (
        (k_rise && !slot_odd && !pin.load_n && !(last_read && !pin.rw)) |=>
            (req_start == (has_start(VARIANT) ? $past({pin.start_hi, pin.start_lo}) : 2'h0)))
        else $error("burst start word misapplied");

    chk_fixed_start_word: assert property (
        (use_req && !has_start(VARIANT)) |-> (idx[1:0] == 2'h0))
        else $error("narrow variant did not start at word zero");

    chk_write_after_read: assert property (
        (k_rise && !slot_odd && last_read && !pin.load_n && !pin.rw) |=>
            (!req_valid && !slot_odd))
        else $error("write after read was not a no-op");

    chk_read_returns: assert property (
        (do_beat && !wr_now) |=> (QVALID_O && (Q_O == $past(mem[idx]))))
        else $error("read word differs from stored word");

    cov_write_burst: cover property (use_req && req_write);
    cov_read_burst: cover property (use_req && !req_write);
    cov_read_nop: cover property (k_rise && !slot_odd && last_read && !pin.load_n && !pin.rw);
    cov_wrapped_start: cover property (use_req && (req_start == 2'h3));

endmodule

//--- burst4_ctrl_model.sv
/*
 * Memory controller model: plays one K period per call, a pin set held
 * across the K rising edge and another across the KN rising edge.
 * Assumes the system clock is the device's CLK_I and pins are seen via sync.
 */
module burst4_ctrl_model
    import burst4_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Pins towards the device
    output pins_t pins_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pins_o = PINS_RESET;

    // One pin change, then held four clocks
    task automatic step(input pins_t p);
        @(posedge clk_i);
        pins_o <= p;
        repeat (3) @(posedge clk_i);
    endtask

    // Words and lane controls held across each rising edge
    task automatic kcycle(input pins_t a, input pins_t b);
        a.k = 1'h0;
        a.kn = 1'h0;
        step(a);
        a.k = 1'h1;
        step(a);
        b.k = 1'h0;
        b.kn = 1'h0;
        step(b);
        b.kn = 1'h1;
        step(b);
    endtask
endmodule

//--- burst4_write_mask_and_order_bench.sv
/*
 * Self-checking bench: all four width variants on one controller model,
 * hand-written corner requests, then random burst traffic.
 * Assumes each controller period spans sixteen system clocks.
 */
module burst4_write_mask_and_order_bench
    import burst4_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int NOPS = 80;
    localparam int NCYC = 2 * NOPS + 3;
    localparam int PW = $bits(pins_t);
    localparam int FK [8] = '{1, 2, 1, 2, 0, 1, 1, 2};
    localparam int FA [8] = '{5, 5, 5, 5, 0, 2, 2, 2};
    localparam int FS [8] = '{1, 1, 1, 3, 0, 3, 0, 2};
    logic clk;
    logic nrst;
    pins_t pins;
    logic [DATA_W-1:0] q [4];
    logic v [4];
    logic [DATA_W-1:0] mem [4][WORDS];
    logic [DATA_W-1:0] expq [4][$];
    pins_t kp [NCYC];
    pins_t np [NCYC];
    int fails;
    int n_compared;

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    burst4_ctrl_model u_ctl (.clk_i(clk), .pins_o(pins));

    task automatic check(input string what, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Lanes a variant stores for given enables
    function automatic logic [DATA_W-1:0] exp_mask(input int vr, input logic [3:0] bw,
        input logic [1:0] nw);
        logic [DATA_W-1:0] m;
        m = '0;
        if (vr == 0)
            m[7:0] = {{4{~nw[1]}}, {4{~nw[0]}}};
        for (int i = 0; i < 4; i++)
            if (vr > 0 && i < ((vr == 3) ? 4 : vr))
                m[i*9 +: 9] = {9{~bw[i]}};
        return m;
    endfunction

    function automatic pins_t rnd_pins();
        pins_t p;
        p = pins_t'(PW'({$urandom, $urandom}));
        p.load_n = 1'h1;
        return p;
    endfunction

    for (genvar g = 0; g < 4; g++)
    begin : g_var
        burst4_write_mask_and_order #(.VARIANT(variant_t'(g))) u_dut (
            .CLK_I(clk), .NRST_I(nrst), .K_I(pins.k), .KN_I(pins.kn),
            .LOAD_REQUEST_N_I(pins.load_n), .READ_NOT_WRITE_I(pins.rw),
            .SYNC_ADDRESS_BUS_I(pins.addr), .BURST_START_BIT_LOW_I(pins.start_lo),
            .BURST_START_BIT_HIGH_I(pins.start_hi), .D_I(pins.d),
            .BYTE_LANE_WRITE_ENABLE_N_I(pins.bw_n),
            .NIBBLE_LANE_WRITE_ENABLE_N_I(pins.nw_n), .Q_O(q[g]), .QVALID_O(v[g]));
        always @(posedge clk)
            if (v[g] === 1'h1 && expq[g].size() == 0)
                check("spare read pulse", 36'h1, 36'h0);
            else if (v[g] === 1'h1)
                check("read word", q[g], expq[g].pop_front());
    end

    initial
    begin
        int kind;
        int prev_read;
        int a;
        int s;
        int c;
        logic [4:0] ad;
        pins_t p;
        nrst = 1'h0;
        fails = 0;
        n_compared = 0;
        void'($urandom(32'hCD99));
        foreach (mem[i, j]) mem[i][j] = '0;
        foreach (kp[i]) kp[i] = rnd_pins();
        foreach (np[i]) np[i] = rnd_pins();
        prev_read = 0;
        for (int i = 0; i < NOPS; i++)
        begin
            c = 2 * i;
            kind = (i < 8) ? FK[i] : $urandom_range(2);
            a = (i < 8) ? FA[i] : $urandom_range(7);
            s = (i < 8) ? FS[i] : $urandom_range(3);
            kp[c].load_n = (kind == 0);
            kp[c].rw = (kind == 2);
            kp[c].addr = 3'(a);
            kp[c].start_lo = s[0];
            kp[c].start_hi = s[1];
            // Ignored request slot right after a taken one
            if (kind == 2 || (kind == 1 && prev_read == 0))
                kp[c + 1].load_n = 1'($urandom_range(1));
            for (int j = 0; j < 4; j++)
            begin
                p = (j % 2 == 0) ? kp[c + 1 + j / 2] : np[c + 1 + j / 2];
                for (int vr = 0; vr < 4; vr++)
                begin
                    ad = {3'(a), 2'(((vr >= 2) ? s : 0) + j)};
                    if (kind == 1 && prev_read == 0)
                        mem[vr][ad] = (mem[vr][ad] & ~exp_mask(vr, p.bw_n, p.nw_n))
                            | (p.d & exp_mask(vr, p.bw_n, p.nw_n));
                    if (kind == 2)
                        expq[vr].push_back(mem[vr][ad]);
                end
            end
            prev_read = (kind == 2);
        end
        repeat (4) @(posedge clk);
        nrst <= 1'h1;
        repeat (6) @(posedge clk);
        for (int g = 0; g < 4; g++)
        begin
            check("reset read word", q[g], '0);
            check("reset valid", {35'h0, v[g]}, '0);
        end
        for (int i = 0; i < NCYC; i++)
            u_ctl.kcycle(kp[i], np[i]);
        repeat (40) @(posedge clk);
        for (int g = 0; g < 4; g++)
            check("words not returned", 36'(expq[g].size()), '0);
        finish_test();
    end

    initial
    begin
        repeat (NCYC * 16 + 2000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule
